// ### bsr_agent.sv
`timescale 1ns/1ns
// Functional notes
// R1: attribute bits driven on address lines 7..3, clock two
// R2: smm flag on every request after smm entry
// R3: split-lock flag only on first split-lock transaction
// R4: defer flag only if deferral acceptable; 2,0 reserved
// R5: stall is shared and modified together one clock
// R6: stall sampled lengthens snoop phase two clocks
// R7: repeat stall every second clock to prolong
// R8: re-drive result after one inactive clock
// R9: modified hit asserts result, then implicit writeback
// R10: modified line goes shared on reads, else invalid
// R11: deferred reply may carry modified result
// R12: shared hit asserted to keep line shared
// R13: shared hit is wired-or of all agents
// R14: shared seen blocks exclusive or modified install
// R15: modified hit beats defer, implicit writeback response
// R16: all these pins active low, rising-edge sampled
module bsr_agent (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  // request side: attributes for our own request
  input  wire logic                        req_second_clk,
  input  wire logic                        smm_active,
  input  wire logic                        split_lock_first,
  input  wire logic                        can_defer,
  output logic [bsr_pkg::ATTR_W-1:0]       second_clock_address_lines_o,
  output logic                             second_clock_address_lines_oe_n,
  // snoop inputs from local cache
  input  wire logic                        snoop_start,
  input  wire logic                        own_request,
  input  wire bsr_pkg::bsr_req_t           snoop_req_kind,
  input  wire bsr_pkg::bsr_line_t          snoop_line_state,
  input  wire logic                        need_stall,
  // shared-hit pin, open drain
  input  wire logic                        shared_hit_n_i,
  output logic                             shared_hit_n_o,
  output logic                             shared_hit_n_oe_n,
  // modified-hit pin, open drain
  input  wire logic                        modified_copy_result_n_i,
  output logic                             modified_copy_result_n_o,
  output logic                             modified_copy_result_n_oe_n,
  // defer pin, input only
  input  wire logic                        defer_n_i,
  // snoop outcome
  output logic                             snoop_done,
  output bsr_pkg::bsr_line_t               line_next_state,
  output logic                             implicit_wb,
  output logic                             deferred_completion,
  output logic                             unexpected_data,
  output logic                             install_limit_shared
);
  import bsr_pkg::*;

  typedef struct packed {
    bsr_snp_t                st;        // snoop sequencer state
    logic [1:0]              ext;       // clocks left in extension
    logic                    drv_hit;   // we drive shared hit
    logic                    drv_modified_copy_result;  // we drive modified hit
    logic                    stalling;  // our result is a stall
    logic                    own;       // snoop of own request
    bsr_req_t                kind;
    bsr_line_t               line;
    logic [ATTR_W-1:0]       attr;      // attribute output, active high
    logic                    attr_en;
    logic                    done;
    bsr_line_t               nxt;
    logic                    wb;
    logic                    dfr;
    logic                    unexp;
    logic                    lim;
  } bsr_st_t;
  bsr_st_t q, d;

  logic [1:0] pin_lvl_n;  // filtered {modified, shared}
  logic       dfr_lvl_n;  // filtered defer
  logic       hit_s, modified_copy_result_s, stall_s;
  logic       live_stall; // both wired pins low at this edge

  // pins come from other agents on the same bus clock;
  // one sampling stage holds the drive clock's levels
  // for the evaluation clock that follows it
  bsr_sync3 #(.W(3)) u_pins (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin_n   ({defer_n_i, modified_copy_result_n_i, shared_hit_n_i}),
    .level_n ({dfr_lvl_n, pin_lvl_n})
  );

  // active-low pins inverted to internal sense
  assign hit_s   = ~pin_lvl_n[0]; // R16 R13
  assign modified_copy_result_s  = ~pin_lvl_n[1]; // R16
  assign stall_s = hit_s & modified_copy_result_s; // R5
  // the stall must be seen at the end of the drive clock itself,
  // otherwise the re-drive would land one clock late
  assign live_stall = ~shared_hit_n_i & ~modified_copy_result_n_i; // R5 R16

  // next state: attributes and snoop sequencing
  always_comb begin
    d      = q;
    d.done = 1'b0;
    // attribute field only during second request clock
    d.attr_en = req_second_clk; // R1
    d.attr    = '0;
    if (req_second_clk) begin
      d.attr[ATTR_SMM_BIT] = smm_active;       // R2
      d.attr[ATTR_SPL_BIT] = split_lock_first; // R3
      d.attr[ATTR_DEN_BIT] = can_defer;        // R4
    end
    case (q.st)
      BSR_IDLE: begin
        if (snoop_start) begin
          d.own  = own_request;
          d.kind = snoop_req_kind;
          d.line = snoop_line_state;
          d.st   = BSR_DRIVE;
          // stall outranks a result; both pins low together
          if (need_stall) begin
            d.stalling = 1'b1;
            d.drv_hit  = 1'b1; // R5
            d.drv_modified_copy_result = 1'b1; // R5
          end else begin
            d.stalling = 1'b0;
            d.drv_modified_copy_result = !own_request && snoop_line_state == BSR_LINE_M; // R9
            d.drv_hit  = !own_request && (snoop_line_state == BSR_LINE_S ||
                         snoop_line_state == BSR_LINE_E); // R12
          end
        end
      end
      BSR_DRIVE: begin
        // one clock of drive; the wires are sampled at its end
        if (live_stall) begin
          // stall seen: two clock extension, the first one quiet
          // so that every agent re-drives on the following clock
          d.ext = STALL_EXT_CLKS - 2'h1; // R6
          d.st  = BSR_GAP; // R8
        end else begin
          // no stall: results are final, wrap up next clock
          d.st = BSR_EVAL;
        end
      end
      BSR_EVAL: begin
        // stall_s is never set here: a stall left drive for the gap
        if (stall_s) begin
          // defensive only; finish on the sampled result anyway
          d.st = BSR_IDLE;
        end
        begin
          d.st    = BSR_IDLE;
          d.done  = 1'b1;
          d.wb    = modified_copy_result_s;            // R15
          d.dfr   = !modified_copy_result_s && !dfr_lvl_n; // R15
          d.unexp = modified_copy_result_s && q.kind == BSR_REQ_DEF_REPLY; // R11
          d.lim   = q.own && hit_s;    // R14
          d.nxt   = q.line;
          if (q.drv_modified_copy_result && !q.stalling) begin
            // reads keep a shared copy, anything else invalidates
            d.nxt = (q.kind == BSR_REQ_READ_LINE || q.kind == BSR_REQ_READ_PART)
                    ? BSR_LINE_S : BSR_LINE_I; // R10
          end else if (q.drv_hit && !q.stalling) begin
            d.nxt = BSR_LINE_S; // R12
          end
          d.drv_hit  = 1'b0;
          d.drv_modified_copy_result = 1'b0;
        end
      end
      BSR_GAP: begin
        // after the quiet clock re-drive the result or a new stall
        // limitation: after snoop start, need_stall is only looked at on this clock
        d.st  = BSR_DRIVE;
        d.ext = 2'h0;
        if (q.stalling && !need_stall) begin
          d.stalling = 1'b0;
          d.drv_modified_copy_result = !q.own && q.line == BSR_LINE_M; // R8 R9
          d.drv_hit  = !q.own && (q.line == BSR_LINE_S || q.line == BSR_LINE_E); // R8
        end else if (q.stalling) begin
          d.drv_hit  = 1'b1; // R7
          d.drv_modified_copy_result = 1'b1; // R7
        end
      end
      default: begin
        d.st = BSR_IDLE;
      end
    endcase
  end

  // single state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '{st: BSR_IDLE, ext: 2'h0, drv_hit: 1'b0, drv_modified_copy_result: 1'b0,
             stalling: 1'b0, own: 1'b0, kind: BSR_REQ_OTHER, line: BSR_LINE_I,
             attr: '0, attr_en: 1'b0, done: 1'b0, nxt: BSR_LINE_I,
             wb: 1'b0, dfr: 1'b0, unexp: 1'b0, lim: 1'b0};
    end else begin
      q <= d;
    end
  end

  // drive only in drive clock; the gap clock stays inactive
  assign shared_hit_n_o                  = 1'b0;
  assign shared_hit_n_oe_n               = !(q.st == BSR_DRIVE && q.drv_hit); // R13
  assign modified_copy_result_n_o        = 1'b0;
  assign modified_copy_result_n_oe_n     = !(q.st == BSR_DRIVE && q.drv_modified_copy_result);
  // attribute lines driven active low, reserved bits inactive
  assign second_clock_address_lines_o    = ~q.attr; // R16 R4
  assign second_clock_address_lines_oe_n = !q.attr_en; // R1
  // outcome flags
  assign snoop_done           = q.done;
  assign line_next_state      = q.nxt;
  assign implicit_wb          = q.wb;
  assign deferred_completion  = q.dfr;
  assign unexpected_data      = q.unexp;
  assign install_limit_shared = q.lim;
endmodule

// ### bsr_peer.sv
`timescale 1ns/1ns
// another caching agent sharing the open-drain snoop pins
module bsr_peer (
  // clock and snoop start
  input  wire logic sys_clk,
  input  wire logic go,
  // wanted result and wired pin levels
  input  wire logic hit,
  input  wire logic stall,
  input  wire logic sh_n,
  input  wire logic hm_n,
  // enables, low pulls the line low
  output logic      hit_oe_n,
  output logic      modified_copy_result_oe_n
);
  logic [1:0] ph = 2'h0; // clocks since start
  logic       st = 1'b0; // stall seen on the wire
  // phase counter, stops after the re-drive clock
  always @(posedge sys_clk) begin
    ph <= go ? 2'h1 : (ph != 2'h0 ? ph + 2'h1 : 2'h0);
    if (ph == 2'h1) begin
      st <= !sh_n && !hm_n;
    end
  end
  // result one clock; re-driven after one idle clock when stalled
  assign hit_oe_n = !((ph == 2'h1 && (hit || stall)) || (ph == 2'h3 && st && hit));
  assign modified_copy_result_oe_n = !(ph == 2'h1 && stall);
endmodule

// ### bsr_pkg.sv
package bsr_pkg;
  // extended-function attribute bit positions within the five-bit field
  localparam int unsigned ATTR_W        = 5;
  localparam int unsigned ATTR_SMM_BIT  = 4;
  localparam int unsigned ATTR_SPL_BIT  = 3;
  localparam int unsigned ATTR_RSV2_BIT = 2;
  localparam int unsigned ATTR_DEN_BIT  = 1;
  localparam int unsigned ATTR_RSV0_BIT = 0;
  // attribute field sits on second-clock address lines 7..3
  localparam int unsigned ATTR_ADDR_LO  = 3;
  // stall extension length in bus clocks
  localparam logic [1:0]  STALL_EXT_CLKS = 2'h2;
  // cache line states
  typedef enum logic [1:0] {
    BSR_LINE_I = 2'b00,
    BSR_LINE_S = 2'b01,
    BSR_LINE_E = 2'b10,
    BSR_LINE_M = 2'b11
  } bsr_line_t;
  // snoop phase sequencer states
  typedef enum logic [1:0] {
    BSR_IDLE  = 2'b00,
    BSR_DRIVE = 2'b01,
    BSR_GAP   = 2'b10,
    BSR_EVAL  = 2'b11
  } bsr_snp_t;
  // request kinds relevant for snoop state effects
  typedef enum logic [2:0] {
    BSR_REQ_READ_LINE = 3'b000,
    BSR_REQ_READ_PART = 3'b001,
    BSR_REQ_READ_INV  = 3'b010,
    BSR_REQ_WRITE     = 3'b011,
    BSR_REQ_DEF_REPLY = 3'b100,
    BSR_REQ_OTHER     = 3'b101
  } bsr_req_t;
endpackage

// ### bsr_props.sv
`timescale 1ns/1ns
// pin-level and snoop outcome checks beside the agent
module bsr_props (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       reset,
  // request attributes
  input wire logic                       req_second_clk,
  input wire logic                       smm_active,
  input wire logic                       split_lock_first,
  input wire logic                       can_defer,
  input wire logic [bsr_pkg::ATTR_W-1:0] second_clock_address_lines_o,
  input wire logic                       second_clock_address_lines_oe_n,
  // snoop pins and outcome
  input wire logic                       shared_hit_n_oe_n,
  input wire logic                       modified_copy_result_n_oe_n,
  input wire logic                       snoop_done,
  input wire bsr_pkg::bsr_line_t         line_next_state,
  input wire logic                       implicit_wb
);
  import bsr_pkg::*;
  wire [4:0] al = second_clock_address_lines_o; // short alias
  wire       ae = second_clock_address_lines_oe_n; // low while driving
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  attr_drive_a: assert property (req_second_clk |=> !ae)
    else $error("attribute lines not driven");
  attr_release_a: assert property (!req_second_clk |=> ae)
    else $error("attribute lines driven outside clock two");
  smm_flag_a: assert property (req_second_clk |=> al[4] == !$past(smm_active))
    else $error("smm flag wrong");
  split_flag_a: assert property (req_second_clk |=> al[3] == !$past(split_lock_first))
    else $error("split lock flag wrong");
  defer_flag_a: assert property (req_second_clk ##1 1'b1 |-> al[1] == !$past(can_defer))
    else $error("defer flag wrong");
  reserved_high_a: assert property (!ae |-> al[2] && al[0])
    else $error("reserved attribute asserted");
  shared_pulse_a: assert property ($fell(shared_hit_n_oe_n) |=> shared_hit_n_oe_n)
    else $error("shared hit held over one clock");
  modified_pulse_a: assert property ($fell(modified_copy_result_n_oe_n) |=> $rose(modified_copy_result_n_oe_n))
    else $error("modified hit held over one clock");
  wb_state_a: assert property (snoop_done && implicit_wb |-> line_next_state inside {BSR_LINE_I, BSR_LINE_S})
    else $error("modified line not demoted");
  done_pulse_a: assert property (snoop_done |=> !snoop_done)
    else $error("done held over one clock");
  cover property (snoop_done && implicit_wb);
  cover property (!shared_hit_n_oe_n && !modified_copy_result_n_oe_n);
  cover property (req_second_clk && smm_active && can_defer);
endmodule
bind bsr_agent bsr_props u_props (.sys_clk, .reset, .req_second_clk, .smm_active,
  .split_lock_first, .can_defer, .second_clock_address_lines_o,
  .second_clock_address_lines_oe_n, .shared_hit_n_oe_n, .modified_copy_result_n_oe_n,
  .snoop_done, .line_next_state, .implicit_wb);

// ### bsr_sync3.sv
`timescale 1ns/1ns
// rising-edge sample register for active-low wired bus pins
module bsr_sync3 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // raw and filtered levels
  input  wire logic [W-1:0] pin_n,
  output logic      [W-1:0] level_n
);
  typedef struct packed {
    logic [W-1:0] lvl; // level seen at the last rising edge
  } bsr_sy_t;
  bsr_sy_t q, d;

  // every agent runs on the bus clock, so one sample is enough;
  // a deeper agreement filter would swallow one-clock snoop pulses
  always_comb begin
    d     = q;
    d.lvl = pin_n;
  end

  // pins idle high (inactive) after reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '{lvl: '1};
    end else begin
      q <= d;
    end
  end

  assign level_n = q.lvl;
endmodule

// ### tb_bsr_agent.sv
`timescale 1ns/1ns
// directed bench for the attribute and snoop agent
module tb_bsr_agent;
  import bsr_pkg::*;
  logic sys_clk = 0, reset = 1, rq = 0, smm = 0, spl = 0, den = 0;
  logic start = 0, own = 0, nstall = 0, defer_n = 1, p_hit = 0, p_stall = 0;
  bsr_req_t  kind = BSR_REQ_READ_LINE;
  bsr_line_t st = BSR_LINE_I;
  logic [4:0] al;
  logic al_oe_n, sh_oe_n, hm_oe_n, p_sh, p_hm, done, wb, dc, ud, ils;
  bsr_line_t nxt;
  wire sh_n = sh_oe_n & p_sh;
  wire hm_n = hm_oe_n & p_hm; // wired line with pull-up
  int errors = 0, n_tests = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  bsr_agent uut (.sys_clk, .reset, .req_second_clk(rq), .smm_active(smm),
    .split_lock_first(spl), .can_defer(den), .second_clock_address_lines_o(al),
    .second_clock_address_lines_oe_n(al_oe_n), .snoop_start(start), .own_request(own),
    .snoop_req_kind(kind), .snoop_line_state(st), .need_stall(nstall),
    .shared_hit_n_i(sh_n), .shared_hit_n_o(), .shared_hit_n_oe_n(sh_oe_n),
    .modified_copy_result_n_i(hm_n), .modified_copy_result_n_o(),
    .modified_copy_result_n_oe_n(hm_oe_n), .defer_n_i(defer_n), .snoop_done(done),
    .line_next_state(nxt), .implicit_wb(wb), .deferred_completion(dc),
    .unexpected_data(ud), .install_limit_shared(ils));
  bsr_peer peer (.sys_clk, .go(start), .hit(p_hit), .stall(p_stall), .sh_n(sh_n),
    .hm_n(hm_n), .hit_oe_n(p_sh), .modified_copy_result_oe_n(p_hm));
  // compare and count
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one request second clock, then the driven field
  task automatic attr(input logic [2:0] a);
    @(posedge sys_clk);
    {rq, smm, spl, den} <= {1'b1, a};
    @(posedge sys_clk);
    rq <= 1'b0;
    #1;
    chk({5'h0, al_oe_n}, 6'h00);
    chk({1'b0, al}, {1'b0, ~{a[2:1], 1'b0, a[0], 1'b0}});
  endtask
  // one snoop phase; c = own, stall, defer, peer hit, peer stall
  task automatic snoop(input bsr_req_t k, input bsr_line_t s, input logic [4:0] c,
                       input logic [5:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    {kind, st, start} <= {k, s, 1'b1};
    {own, nstall, defer_n, p_hit, p_stall} <= {c[4:3], ~c[2], c[1:0]};
    @(posedge sys_clk);
    {start, nstall} <= 2'h0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 40);
    chk({c[4] ? 2'h0 : nxt, wb, dc, ud, ils}, exp);
    $display("snoop test done at %0t", $time);
  endtask
  // run-away guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) attr(3'(i));
    $display("attribute test done");
    snoop(BSR_REQ_READ_LINE, BSR_LINE_M, 5'h00, 6'h18);
    snoop(BSR_REQ_READ_PART, BSR_LINE_M, 5'h00, 6'h18);
    snoop(BSR_REQ_READ_INV, BSR_LINE_M, 5'h00, 6'h08);
    snoop(BSR_REQ_WRITE, BSR_LINE_M, 5'h00, 6'h08);
    snoop(BSR_REQ_OTHER, BSR_LINE_M, 5'h00, 6'h08);
    snoop(BSR_REQ_DEF_REPLY, BSR_LINE_M, 5'h00, 6'h0a);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_M, 5'h04, 6'h18);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_I, 5'h04, 6'h04);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_S, 5'h00, 6'h10);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_E, 5'h00, 6'h10);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_I, 5'h12, 6'h01);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_I, 5'h10, 6'h00);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_M, 5'h08, 6'h18);
    snoop(BSR_REQ_READ_LINE, BSR_LINE_S, 5'h01, 6'h10);
    wrap_up;
  end
endmodule
